// [ddc_cfg_pkg.sv]
package ddc_cfg_pkg;

  // ************************************************************
  // Bus and word geometry
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam int BYTE_W = 8;
  localparam int NUM_BYTES = 6;
  localparam int NCO_W = 48;
  localparam int SAMPLE_W = 14;
  localparam logic [1:0] ALIGN_OK = 2'h0;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [IDX_W-1:0] ROUTE_IDX = 10'h311;
  localparam logic [IDX_W-1:0] TEST_IDX = 10'h327;
  localparam logic [IDX_W-1:0] FREQ_IDX [NUM_BYTES] = '{
    10'h314, 10'h315, 10'h316, 10'h317, 10'h318, 10'h31a};
  localparam logic [IDX_W-1:0] PHASE_IDX [NUM_BYTES] = '{
    10'h31d, 10'h31e, 10'h31f, 10'h320, 10'h321, 10'h322};
  localparam logic [IDX_W-1:0] UNMAPPED_IDX = 10'h000;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int I_SEL_BIT = 0;
  localparam int Q_SEL_BIT = 2;
  localparam int I_TEST_BIT = 0;
  localparam int Q_TEST_BIT = 2;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  localparam logic [NCO_W-1:0] WORD_RESET = 48'h0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } iq_sample_t;

  typedef struct packed {
    logic i_sel;
    logic q_sel;
    logic i_test;
    logic q_test;
  } path_cfg_t;

endpackage

// [nco_accum.sv]
`timescale 1ns/1ps

module nco_accum #(
  parameter int W = ddc_cfg_pkg::NCO_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic step_en_i,
  input wire logic [W-1:0] freq_i,
  input wire logic [W-1:0] offset_i,
  // Phase out
  output logic [W-1:0] phase_o
);

  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic [W-1:0] next_phase;

  // Wraps modulo 2^W, so a negative word turns the phasor backwards
  assign next_acc = acc + freq_i;
  assign next_phase = acc + offset_i;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc <= '0;
    end else if (step_en_i) begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_o <= '0;
    end else begin
      phase_o <= next_phase;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_nco_advance: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    step_en_i ##1 !step_en_i |=>
      phase_o == W'($past(acc, 2) + $past(freq_i, 2) + $past(offset_i)))
    else $error("accumulator did not advance by the frequency word");

  a_nco_hold: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    !step_en_i |=> acc == $past(acc))
    else $error("accumulator moved without a sample step");

endmodule // nco_accum

// [ddc_nco_input_config.sv]
`timescale 1ns/1ps

// Behaviour
// - Routing bit2 picks Q source A/C or B/D
// - Routing bit0 picks I source A or B
// - Six byte registers form 48-bit frequency word
// - Accumulator advances by frequency word per sample
// - Six byte registers form 48-bit phase offset
// - Test bit2 takes Q from second pattern
// - Test bit0 takes I from first pattern
module ddc_nco_input_config #(
  parameter int SAMPLE_W = ddc_cfg_pkg::SAMPLE_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ddc_cfg_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [ddc_cfg_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [ddc_cfg_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sample inputs
  input wire logic sample_en_i,
  input wire logic [SAMPLE_W-1:0] adc_even_i,
  input wire logic [SAMPLE_W-1:0] adc_odd_i,
  input wire logic [SAMPLE_W-1:0] tp_first_i,
  input wire logic [SAMPLE_W-1:0] tp_second_i,
  // Path outputs
  output ddc_cfg_pkg::iq_sample_t iq_o,
  output logic iq_valid_o,
  output logic [ddc_cfg_pkg::NCO_W-1:0] nco_phase_o
);

  localparam int NB = ddc_cfg_pkg::NUM_BYTES;
  localparam int BW = ddc_cfg_pkg::BYTE_W;
  localparam int DATA_W = ddc_cfg_pkg::DATA_W;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic [ddc_cfg_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic hit_route;
  logic hit_test;
  logic [NB-1:0] hit_freq;
  logic [NB-1:0] hit_phase;
  logic mapped;
  logic setup;
  logic wr_ok;

  assign idx = paddr_i[ddc_cfg_pkg::IDX_LSB +: ddc_cfg_pkg::IDX_W];
  assign aligned = paddr_i[1:0] == ddc_cfg_pkg::ALIGN_OK;
  assign hit_route = aligned && idx == ddc_cfg_pkg::ROUTE_IDX;
  assign hit_test = aligned && idx == ddc_cfg_pkg::TEST_IDX;
  assign mapped = hit_route | hit_test | (|hit_freq) | (|hit_phase);
  assign setup = psel_i & ~penable_i;
  // Only the low lane carries a register byte
  assign wr_ok = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o &
                 pstrb_i[0];

  // ************************************************************
  // Register storage
  // ************************************************************
  ddc_cfg_pkg::path_cfg_t cfg;
  logic [ddc_cfg_pkg::NCO_W-1:0] freq_word;
  logic [ddc_cfg_pkg::NCO_W-1:0] phase_word;
  logic [BW-1:0] route_rd;
  logic [BW-1:0] test_rd;
  logic [BW-1:0] byte_acc [NB+1];
  logic [BW-1:0] rd_byte;

  genvar k;
  generate
    for (k = 0; k < NB; k++) begin : g_bytes
      assign hit_freq[k] = aligned && idx == ddc_cfg_pkg::FREQ_IDX[k];
      assign hit_phase[k] = aligned && idx == ddc_cfg_pkg::PHASE_IDX[k];
      assign byte_acc[k+1] = byte_acc[k] |
        (hit_freq[k] ? freq_word[k*BW +: BW] : ddc_cfg_pkg::BYTE_RESET) |
        (hit_phase[k] ? phase_word[k*BW +: BW] : ddc_cfg_pkg::BYTE_RESET);

      always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          freq_word[k*BW +: BW] <= ddc_cfg_pkg::BYTE_RESET;
        end else if (wr_ok && hit_freq[k]) begin
          freq_word[k*BW +: BW] <= pwdata_i[BW-1:0];
        end
      end

      always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          phase_word[k*BW +: BW] <= ddc_cfg_pkg::BYTE_RESET;
        end else if (wr_ok && hit_phase[k]) begin
          phase_word[k*BW +: BW] <= pwdata_i[BW-1:0];
        end
      end
    end
  endgenerate

  assign byte_acc[0] = ddc_cfg_pkg::BYTE_RESET;

  // Reserved positions stay zero on read
  assign route_rd = (BW'(cfg.i_sel) << ddc_cfg_pkg::I_SEL_BIT) |
                    (BW'(cfg.q_sel) << ddc_cfg_pkg::Q_SEL_BIT);
  assign test_rd = (BW'(cfg.i_test) << ddc_cfg_pkg::I_TEST_BIT) |
                   (BW'(cfg.q_test) << ddc_cfg_pkg::Q_TEST_BIT);
  assign rd_byte = byte_acc[NB] |
    (hit_route ? route_rd : ddc_cfg_pkg::BYTE_RESET) |
    (hit_test ? test_rd : ddc_cfg_pkg::BYTE_RESET);

  // Only the defined bits are stored; the rest of a write is dropped
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg.i_sel <= 1'b0;
      cfg.q_sel <= 1'b0;
    end else if (wr_ok && hit_route) begin
      cfg.i_sel <= pwdata_i[ddc_cfg_pkg::I_SEL_BIT];
      cfg.q_sel <= pwdata_i[ddc_cfg_pkg::Q_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg.i_test <= 1'b0;
      cfg.q_test <= 1'b0;
    end else if (wr_ok && hit_test) begin
      cfg.i_test <= pwdata_i[ddc_cfg_pkg::I_TEST_BIT];
      cfg.q_test <= pwdata_i[ddc_cfg_pkg::Q_TEST_BIT];
    end
  end

  // ************************************************************
  // APB answer
  // ************************************************************
  // Answer is prepared in setup, so the access phase has no wait state
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup & ~mapped;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= ddc_cfg_pkg::RDATA_RESET;
    end else if (setup) begin
      prdata_o <= (mapped && !pwrite_i) ? DATA_W'(rd_byte)
                                        : ddc_cfg_pkg::RDATA_RESET;
    end
  end

  // ************************************************************
  // Input routing and test selection
  // ************************************************************
  logic [SAMPLE_W-1:0] next_i;
  logic [SAMPLE_W-1:0] next_q;
  logic [SAMPLE_W-1:0] route_i;
  logic [SAMPLE_W-1:0] route_q;

  assign route_i = cfg.i_sel ? adc_odd_i : adc_even_i;
  assign route_q = cfg.q_sel ? adc_odd_i : adc_even_i;
  assign next_i = cfg.i_test ? tp_first_i : route_i;
  assign next_q = cfg.q_test ? tp_second_i : route_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      iq_o <= '0;
      iq_valid_o <= 1'b0;
    end else begin
      iq_valid_o <= sample_en_i;
      if (sample_en_i) begin
        iq_o.i <= next_i;
        iq_o.q <= next_q;
      end
    end
  end

  // ************************************************************
  // Oscillator
  // ************************************************************
  nco_accum #(
    .W(ddc_cfg_pkg::NCO_W)
  ) u_nco (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .step_en_i(sample_en_i),
    .freq_i(freq_word),
    .offset_i(phase_word),
    .phase_o(nco_phase_o)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wr_access(logic [9:0] at);
    psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] &&
      !pslverr_o && aligned && idx == at;
  endsequence

  sequence s_rd_setup(logic [9:0] at);
    setup && !pwrite_i && aligned && idx == at;
  endsequence

  a_route_q_sel: assert property (
    sample_en_i && !cfg.q_test |=>
      iq_o.q == ($past(cfg.q_sel) ? $past(adc_odd_i) : $past(adc_even_i)))
    else $error("Q path took the wrong channel");

  a_route_i_sel: assert property (
    sample_en_i && !cfg.i_test |=>
      iq_o.i == ($past(cfg.i_sel) ? $past(adc_odd_i) : $past(adc_even_i)))
    else $error("I path took the wrong channel");

  a_freq_low_byte: assert property (
    s_wr_access(ddc_cfg_pkg::FREQ_IDX[0]) |=>
      freq_word[7:0] == $past(pwdata_i[7:0]))
    else $error("frequency low byte not written");

  a_freq_high_byte: assert property (
    s_wr_access(ddc_cfg_pkg::FREQ_IDX[NB-1]) |=>
      freq_word[47:40] == $past(pwdata_i[7:0]) &&
      $stable(freq_word[39:0]))
    else $error("frequency high byte not written alone");

  a_phase_high_byte: assert property (
    s_wr_access(ddc_cfg_pkg::PHASE_IDX[NB-1]) |=>
      phase_word[47:40] == $past(pwdata_i[7:0]))
    else $error("phase offset high byte not written");

  a_test_q_pattern: assert property (
    sample_en_i && cfg.q_test |=> iq_valid_o && iq_o.q == $past(tp_second_i))
    else $error("Q test mode did not use second pattern");

  a_test_i_pattern: assert property (
    sample_en_i && cfg.i_test |=> iq_valid_o && iq_o.i == $past(tp_first_i))
    else $error("I test mode did not use first pattern");

  a_reserved_read: assert property (
    s_rd_setup(ddc_cfg_pkg::ROUTE_IDX) |=>
      pready_o && !pslverr_o && prdata_o[31:3] == '0 && !prdata_o[1])
    else $error("reserved routing bits read nonzero");

  a_unmapped_err: assert property (
    setup && idx == ddc_cfg_pkg::UNMAPPED_IDX |=> pready_o && pslverr_o)
    else $error("unmapped address not refused");

  sequence s_refused_access;
    psel_i && penable_i && pready_o && pslverr_o;
  endsequence

  a_ready_after_setup: assert property (
    setup |=> pready_o)
    else $error("no ready in the cycle after setup");

  a_ready_one_cycle: assert property (
    pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");

  a_ready_cause: assert property (
    pready_o |-> $past(setup))
    else $error("ready without a setup cycle");

  a_error_with_ready: assert property (
    pslverr_o |-> pready_o)
    else $error("error raised outside an access");

  a_refused_data: assert property (
    setup && !mapped |=> prdata_o == ddc_cfg_pkg::RDATA_RESET)
    else $error("refused read returned data");

  a_refused_write: assert property (
    s_refused_access |=>
      $stable(freq_word) && $stable(phase_word) && $stable(cfg))
    else $error("refused access changed a register");

  a_strobe_drop: assert property (
    psel_i && penable_i && pready_o && !pstrb_i[0] |=>
      $stable(freq_word) && $stable(phase_word) && $stable(cfg))
    else $error("write without low strobe changed a register");

  a_read_no_side: assert property (
    psel_i && penable_i && !pwrite_i |=>
      $stable(freq_word) && $stable(phase_word) && $stable(cfg))
    else $error("read access changed a register");

  a_phase_low_byte: assert property (
    s_wr_access(ddc_cfg_pkg::PHASE_IDX[0]) |=>
      phase_word[7:0] == $past(pwdata_i[7:0]) &&
      $stable(phase_word[47:8]))
    else $error("phase offset low byte not written alone");

  a_route_write: assert property (
    s_wr_access(ddc_cfg_pkg::ROUTE_IDX) |=>
      cfg.q_sel == $past(pwdata_i[ddc_cfg_pkg::Q_SEL_BIT]) &&
      cfg.i_sel == $past(pwdata_i[ddc_cfg_pkg::I_SEL_BIT]))
    else $error("routing selects not taken from a write");

  a_test_write: assert property (
    s_wr_access(ddc_cfg_pkg::TEST_IDX) |=>
      cfg.q_test == $past(pwdata_i[ddc_cfg_pkg::Q_TEST_BIT]) &&
      cfg.i_test == $past(pwdata_i[ddc_cfg_pkg::I_TEST_BIT]))
    else $error("test enables not taken from a write");

  a_test_reserved: assert property (
    s_rd_setup(ddc_cfg_pkg::TEST_IDX) |=>
      pready_o && !pslverr_o && prdata_o[31:3] == '0 && !prdata_o[1])
    else $error("reserved test bits read nonzero");

  a_valid_cause: assert property (
    iq_valid_o |-> $past(sample_en_i))
    else $error("valid without a sample");

  a_valid_pulse: assert property (
    !sample_en_i |=> !iq_valid_o)
    else $error("valid stood without a sample");

  a_iq_hold: assert property (
    !sample_en_i |=> $stable(iq_o))
    else $error("sample pair moved without a sample");

  generate
    for (k = 0; k < NB; k++) begin : g_byte_checks
      a_freq_readback: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        s_rd_setup(ddc_cfg_pkg::FREQ_IDX[k]) |=>
          prdata_o == DATA_W'($past(freq_word[k*BW +: BW])))
        else $error("frequency byte read back wrong");

      a_phase_readback: assert property (
        @(posedge core_clk_i) disable iff (sys_rst_i)
        s_rd_setup(ddc_cfg_pkg::PHASE_IDX[k]) |=>
          prdata_o == DATA_W'($past(phase_word[k*BW +: BW])))
        else $error("phase offset byte read back wrong");
    end
  endgenerate

endmodule // ddc_nco_input_config

// [test_ddc_nco_input_config.sv]
`timescale 1ns/1ps

module test_ddc_nco_input_config;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sample_en = 1'b0;
  logic [13:0] even = 14'h0000;
  logic [13:0] odd = 14'h0000;
  logic [13:0] tp1 = 14'h0000;
  logic [13:0] tp2 = 14'h0000;
  ddc_cfg_pkg::iq_sample_t iq;
  logic iq_valid;
  logic [47:0] phase;
  int err_count = 0;
  int compares = 0;
  logic [47:0] freq = 48'hfffe_dcba_9876;
  logic [47:0] offs = 48'h1234_5678_9abc;

  always #2 core_clk_i = ~core_clk_i;

  ddc_nco_input_config u_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sample_en_i(sample_en), .adc_even_i(even), .adc_odd_i(odd),
    .tp_first_i(tp1), .tp_second_i(tp2),
    .iq_o(iq), .iq_valid_o(iq_valid), .nco_phase_o(phase)
  );

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // Bus access
  // ************************************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, output logic [31:0] rv,
                     output logic er);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    // Wait states end only by the answer or by the watchdog
    while (pready !== 1'b1) begin
      @(posedge core_clk_i);
    end
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] rv;
    logic er;
    apb(1'b1, {idx, 2'b00}, d, rv, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic exp_er);
    logic [31:0] rv;
    logic er;
    apb(1'b0, a, 8'h00, rv, er);
    check({16'h0, rv}, {16'h0, exp});
    check({47'h0, er}, {47'h0, exp_er});
  endtask

  // One sample in, routed pair checked one cycle later
  task automatic sample(input logic [27:0] exp);
    @(posedge core_clk_i);
    sample_en <= 1'b1;
    @(posedge core_clk_i);
    sample_en <= 1'b0;
    @(posedge core_clk_i);
    check({47'h0, iq_valid}, 48'h1);
    check({20'h0, iq}, {20'h0, exp});
  endtask

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [13:0] ei;
    logic [13:0] eq;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd({ddc_cfg_pkg::ROUTE_IDX, 2'b00}, 32'h0, 1'b0);
    rd({ddc_cfg_pkg::TEST_IDX, 2'b00}, 32'h0, 1'b0);
    for (int b = 0; b < 6; b++) begin
      rd({ddc_cfg_pkg::FREQ_IDX[b], 2'b00}, 32'h0, 1'b0);
      rd({ddc_cfg_pkg::PHASE_IDX[b], 2'b00}, 32'h0, 1'b0);
    end
    even <= 14'h1234;
    odd <= 14'h2bcd;
    tp1 <= 14'h0f0f;
    tp2 <= 14'h3c3c;
    for (int k = 0; k < 16; k++) begin
      wr(ddc_cfg_pkg::ROUTE_IDX, 8'hfa | {5'h0, k[1], 1'b0, k[0]});
      wr(ddc_cfg_pkg::TEST_IDX, 8'hfa | {5'h0, k[3], 1'b0, k[2]});
      rd({ddc_cfg_pkg::ROUTE_IDX, 2'b00}, {29'h0, k[1], 1'b0, k[0]},
         1'b0);
      rd({ddc_cfg_pkg::TEST_IDX, 2'b00}, {29'h0, k[3], 1'b0, k[2]},
         1'b0);
      ei = k[2] ? 14'h0f0f : (k[0] ? 14'h2bcd : 14'h1234);
      eq = k[3] ? 14'h3c3c : (k[1] ? 14'h2bcd : 14'h1234);
      sample({ei, eq});
    end
    for (int b = 0; b < 6; b++) begin
      wr(ddc_cfg_pkg::FREQ_IDX[b], freq[8*b+:8]);
      wr(ddc_cfg_pkg::PHASE_IDX[b], offs[8*b+:8]);
    end
    for (int b = 0; b < 6; b++) begin
      rd({ddc_cfg_pkg::FREQ_IDX[b], 2'b00}, {24'h0, freq[8*b+:8]},
         1'b0);
      rd({ddc_cfg_pkg::PHASE_IDX[b], 2'b00}, {24'h0, offs[8*b+:8]},
         1'b0);
    end
    check(phase, offs);
    // Three samples back to back advance the accumulator three steps
    @(posedge core_clk_i);
    sample_en <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    sample_en <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    check(phase, offs + freq * 3);
    // Refused places: skipped index, empty index, misaligned address
    rd(12'hc64, 32'h0, 1'b1);
    rd(12'h000, 32'h0, 1'b1);
    rd({ddc_cfg_pkg::ROUTE_IDX, 2'b01}, 32'h0, 1'b1);
    // A write with its low strobe clear leaves the byte alone
    pstrb <= 4'h0;
    wr(ddc_cfg_pkg::FREQ_IDX[0], 8'h55);
    pstrb <= 4'hf;
    rd({ddc_cfg_pkg::FREQ_IDX[0], 2'b00}, {24'h0, freq[7:0]},
       1'b0);
    results();
  end

  initial begin
    #40000;
    err_count++;
    results();
  end
endmodule // test_ddc_nco_input_config
